// ===== core/crx_defs.svh
`ifndef CRX_DEFS_SVH
`define CRX_DEFS_SVH

// Instruction field positions
`define CRX_F3_HI 15
`define CRX_F3_LO 13
`define CRX_OFS_HI 12
`define CRX_OFS_LO 10
`define CRX_RS1_HI 9
`define CRX_RS1_LO 7
`define CRX_B6 6
`define CRX_B5 5
`define CRX_RD_HI 4
`define CRX_RD_LO 2
`define CRX_QUAD 2'b00

// Funct3 encodings
`define CRX_F3_FLD_LQ 3'h1
`define CRX_F3_LW 3'h2
`define CRX_F3_FLW_LD 3'h3
`define CRX_F3_FSD_SQ 3'h5
`define CRX_F3_SW 3'h6
`define CRX_F3_FSW_SD 3'h7

// Compact register base
`define CRX_REG_BASE 5'h08

// Base widths
`define CRX_XLEN32 2'h0
`define CRX_XLEN64 2'h1
`define CRX_XLEN128 2'h2

`endif

// ===== core/crx_pkg.sv
package crx_pkg;
  typedef enum logic [2:0] {
    CRX_SZ_W = 3'h2,
    CRX_SZ_D = 3'h3,
    CRX_SZ_Q = 3'h4
  } crx_size_t;

  typedef enum logic [1:0] {
    CRX_ST_IDLE = 2'h0,
    CRX_ST_VALID = 2'h1
  } crx_state_t;

  typedef struct packed {
    crx_state_t st;
    logic is_store;
    logic is_fp;
    logic illegal;
    crx_size_t size;
    logic [4:0] rd;
    logic [4:0] rs1;
    logic [8:0] ofs;
  } crx_state_rec_t;

  typedef struct packed {
    logic [4:0] idx;
  } crx_regmap_t;
endpackage

// ===== core/crx_reg_map.sv
`timescale 1ns/10ps
`include "crx_defs.svh"
// Compact register field to full register index
module crx_reg_map
  import crx_pkg::*;
(
  input wire logic [2:0] field,
  output logic [4:0] idx
);
  // Add eight to the field
  assign idx = `CRX_REG_BASE | {2'h0, field};
endmodule

// ===== core/crx_ofs_unscramble.sv
`timescale 1ns/10ps
`include "crx_defs.svh"
// Rebuilds the zero-extended byte offset
module crx_ofs_unscramble
  import crx_pkg::*;
(
  input wire logic [15:0] instr,
  input wire logic [2:0] size,
  output logic [8:0] ofs
);
  always_comb begin
    ofs = 9'h000;
    case (size)
      3'h2: begin
        ofs[5:3] = instr[`CRX_OFS_HI:`CRX_OFS_LO];
        ofs[2] = instr[`CRX_B6];
        ofs[6] = instr[`CRX_B5];
      end
      3'h3: begin
        ofs[5:3] = instr[`CRX_OFS_HI:`CRX_OFS_LO];
        ofs[7:6] = instr[`CRX_B6:`CRX_B5];
      end
      3'h4: begin
        ofs[5:4] = instr[12:11];
        ofs[8] = instr[10];
        ofs[7:6] = instr[`CRX_B6:`CRX_B5];
      end
      default: begin
        ofs = 9'h000;
      end
    endcase
  end
endmodule

// ===== core/crx_expander.sv
`timescale 1ns/10ps
`include "crx_defs.svh"
// Overview of operation
// - Loads are decoded from funct3 15:13, offset 12:10 and 6:5, base 9:7, destination 4:2, quadrant 00.
// - Stores use the same layout with bits 4:2 naming the compact source register.
// - Word load reads 32 bits at base plus zero-extended offset times 4.
// - Doubleword load exists only on 64/128-bit bases and uses offset times 8.
// - Quadword load exists only on the 128-bit base and uses offset times 16.
// - Single float load exists on 32-bit base with F and uses offset times 4.
// - Double float load exists on 32/64-bit base with D and uses offset times 8.
// - Word store writes 32 bits at base plus offset times 4.
// - Doubleword store exists only on 64/128-bit bases with offset times 8.
// - Quadword store exists only on the 128-bit base with offset times 16.
// - Single float store exists on 32-bit base with F, offset times 4.
// - Double float store exists on 32/64-bit base with D, offset times 8.
module crx_expander
  import crx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [15:0] in_instr,
  input wire logic [1:0] xlen_sel,
  input wire logic has_f,
  input wire logic has_d,
  output logic out_valid,
  output logic out_is_store,
  output logic out_is_fp,
  output logic out_illegal,
  output logic [2:0] out_size,
  output logic [4:0] out_rd,
  output logic [4:0] out_rs1,
  output logic [8:0] out_ofs
);

  // ****************************************
  // Field decode
  // ****************************************
  logic [2:0] f3;
  logic quad_ok;
  logic [4:0] rs1_idx;
  logic [4:0] rd_idx;
  logic [8:0] ofs_w;
  logic dec_store;
  logic dec_fp;
  logic dec_ok;
  crx_size_t dec_size;
  crx_state_rec_t cur_ff;
  crx_state_rec_t nxt_cur;

  assign f3 = in_instr[`CRX_F3_HI:`CRX_F3_LO];
  assign quad_ok = in_instr[1:0] == `CRX_QUAD;

  crx_reg_map u_map_rs1 (
    .field(in_instr[`CRX_RS1_HI:`CRX_RS1_LO]),
    .idx(rs1_idx)
  );

  // bits 4:2 as dest or source
  crx_reg_map u_map_rd (
    .field(in_instr[`CRX_RD_HI:`CRX_RD_LO]),
    .idx(rd_idx)
  );

  crx_ofs_unscramble u_ofs (
    .instr(in_instr),
    .size(dec_size),
    .ofs(ofs_w)
  );

  // ****************************************
  // Operation select
  // ****************************************
  always_comb begin
    dec_store = 1'b0;
    dec_fp = 1'b0;
    dec_ok = 1'b0;
    dec_size = CRX_SZ_W;
    case (f3)
      `CRX_F3_LW, `CRX_F3_SW: begin
        dec_store = f3 == `CRX_F3_SW;
        dec_ok = 1'b1;
      end
      `CRX_F3_FLD_LQ, `CRX_F3_FSD_SQ: begin
        dec_store = f3 == `CRX_F3_FSD_SQ;
        if (xlen_sel == `CRX_XLEN128) begin
          dec_size = CRX_SZ_Q;
          dec_ok = 1'b1;
        end else begin
          dec_size = CRX_SZ_D;
          dec_fp = 1'b1;
          dec_ok = has_d;
        end
      end
      `CRX_F3_FLW_LD, `CRX_F3_FSW_SD: begin
        dec_store = f3 == `CRX_F3_FSW_SD;
        if (xlen_sel == `CRX_XLEN32) begin
          dec_fp = 1'b1;
          dec_ok = has_f;
        end else begin
          dec_size = CRX_SZ_D;
          dec_ok = 1'b1;
        end
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Output register
  // ****************************************
  // Capture decode on each accepted request
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.st = in_valid ? CRX_ST_VALID : CRX_ST_IDLE;
    if (in_valid) begin
      nxt_cur.is_store = dec_store;
      nxt_cur.is_fp = dec_fp;
      nxt_cur.illegal = !(dec_ok && quad_ok);
      nxt_cur.size = dec_size;
      nxt_cur.rd = rd_idx;
      nxt_cur.rs1 = rs1_idx;
      nxt_cur.ofs = ofs_w;
    end
  end

  // State register, async reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '{st: CRX_ST_IDLE, is_store: 1'b0, is_fp: 1'b0, illegal: 1'b0,
                  size: CRX_SZ_W, rd: 5'h00, rs1: 5'h00, ofs: 9'h000};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from the state register
  assign out_valid = cur_ff.st == CRX_ST_VALID;
  assign out_is_store = cur_ff.is_store;
  assign out_is_fp = cur_ff.is_fp;
  assign out_illegal = cur_ff.illegal;
  assign out_size = cur_ff.size;
  assign out_rd = cur_ff.rd;
  assign out_rs1 = cur_ff.rs1;
  assign out_ofs = cur_ff.ofs;

  // ****************************************
  // Checks
  // ****************************************
  regmap_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid |-> out_rd[4:3] == 2'h1 && out_rs1[4:3] == 2'h1)
    else $error("compact register outside 8..15");
  word_scale_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid && out_size == 3'h2 |-> out_ofs[1:0] == 2'h0 && out_ofs[8:7] == 2'h0)
    else $error("word offset not scaled by 4");
  dword_scale_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid && out_size == 3'h3 |-> out_ofs[2:0] == 3'h0 && !out_ofs[8])
    else $error("doubleword offset not scaled by 8");
  qword_scale_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid && out_size == 3'h4 |-> out_ofs[3:0] == 4'h0)
    else $error("quadword offset not scaled by 16");
  quad_only_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid && out_size == 3'h4 |-> $past(xlen_sel) == `CRX_XLEN128)
    else $error("quadword outside 128-bit base");
  store_f3_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[14:13] != 2'h0 |=> out_is_store == $past(in_instr[15]))
    else $error("store flag does not follow funct3");
  fp_base_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && xlen_sel == `CRX_XLEN32 && in_instr[14:13] == 2'h3 |=> out_is_fp && out_size == 3'h2)
    else $error("single float not decoded on 32-bit base");
  dfp_base_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && xlen_sel != `CRX_XLEN128 && in_instr[14:13] == 2'h1 |=> out_is_fp && out_size == 3'h3)
    else $error("double float not decoded");
  word_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[14:13] == 2'h2 |=> out_ofs[6] == $past(in_instr[5]) && out_ofs[2] == $past(in_instr[6]))
    else $error("word offset bits misplaced");
  quadrant_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[1:0] != 2'h0 |=> out_illegal)
    else $error("wrong quadrant accepted");

  // ****************************************
  // Request to result checks
  // ****************************************
  // One result per accepted request
  valid_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid |=> out_valid)
    else $error("accepted request gave no result");
  // No result without a request
  valid_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !in_valid |=> !out_valid)
    else $error("result without request");
  // Fields hold between requests
  field_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !in_valid |=> $stable(out_ofs) && $stable(out_rd) && $stable(out_rs1) && $stable(out_size))
    else $error("result fields moved while idle");

  // ****************************************
  // Register field checks
  // ****************************************
  // Base register is eight plus field
  base_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid |=> out_rs1 == {2'h1, $past(in_instr[`CRX_RS1_HI:`CRX_RS1_LO])})
    else $error("base register mapped wrongly");
  // Data register is eight plus field
  data_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid |=> out_rd == {2'h1, $past(in_instr[`CRX_RD_HI:`CRX_RD_LO])})
    else $error("data register mapped wrongly");
  // Stores name their source in bits 4:2
  store_src_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15] && in_instr[14:13] != 2'h0 |=> out_is_store && out_rd[2:0] == $past(in_instr[4:2]))
    else $error("store source field misplaced");
  // Loads never flagged as stores
  load_dir_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && !in_instr[15] |=> !out_is_store)
    else $error("load decoded as store");

  // ****************************************
  // Operation checks
  // ****************************************
  // Word load, integer and legal
  word_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_LW && in_instr[1:0] == `CRX_QUAD
    |=> !out_illegal && !out_is_fp && !out_is_store && out_size == 3'h2)
    else $error("word load decoded wrongly");
  // Word store, integer and legal
  word_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_SW && in_instr[1:0] == `CRX_QUAD
    |=> !out_illegal && !out_is_fp && out_is_store && out_size == 3'h2)
    else $error("word store decoded wrongly");
  // Doubleword load on wide bases
  dword_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_FLW_LD && in_instr[1:0] == `CRX_QUAD && xlen_sel != `CRX_XLEN32
    |=> !out_illegal && !out_is_fp && !out_is_store && out_size == 3'h3)
    else $error("doubleword load decoded wrongly");
  // Doubleword store on wide bases
  dword_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_FSW_SD && in_instr[1:0] == `CRX_QUAD && xlen_sel != `CRX_XLEN32
    |=> !out_illegal && !out_is_fp && out_is_store && out_size == 3'h3)
    else $error("doubleword store decoded wrongly");
  // Quadword load on 128-bit base
  qword_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_FLD_LQ && in_instr[1:0] == `CRX_QUAD && xlen_sel == `CRX_XLEN128
    |=> !out_illegal && !out_is_fp && !out_is_store && out_size == 3'h4)
    else $error("quadword load decoded wrongly");
  // Quadword store on 128-bit base
  qword_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_FSD_SQ && in_instr[1:0] == `CRX_QUAD && xlen_sel == `CRX_XLEN128
    |=> !out_illegal && !out_is_fp && out_is_store && out_size == 3'h4)
    else $error("quadword store decoded wrongly");
  // Single float load gated by F
  sfp_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_FLW_LD && in_instr[1:0] == `CRX_QUAD && xlen_sel == `CRX_XLEN32
    |=> out_is_fp && !out_is_store && out_illegal == !$past(has_f))
    else $error("single float load decoded wrongly");
  // Single float store gated by F
  sfp_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_FSW_SD && in_instr[1:0] == `CRX_QUAD && xlen_sel == `CRX_XLEN32
    |=> out_is_fp && out_is_store && out_illegal == !$past(has_f))
    else $error("single float store decoded wrongly");
  // Double float load gated by D
  dfp_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_FLD_LQ && in_instr[1:0] == `CRX_QUAD && xlen_sel != `CRX_XLEN128
    |=> out_is_fp && !out_is_store && out_illegal == !$past(has_d))
    else $error("double float load decoded wrongly");
  // Double float store gated by D
  dfp_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[15:13] == `CRX_F3_FSD_SQ && in_instr[1:0] == `CRX_QUAD && xlen_sel != `CRX_XLEN128
    |=> out_is_fp && out_is_store && out_illegal == !$past(has_d))
    else $error("double float store decoded wrongly");
  // Funct3 000 and 100 are not ours
  no_op_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[14:13] == 2'h0 |=> out_illegal)
    else $error("non load/store funct3 accepted");

  // ****************************************
  // Offset checks
  // ****************************************
  // Word offset upper bits
  word_hi_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[14:13] == 2'h2 |=> out_ofs[5:3] == $past(in_instr[12:10]))
    else $error("word offset bits 5:3 misplaced");
  // Doubleword offset bits
  dword_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[14:13] == 2'h3 && xlen_sel != `CRX_XLEN32 |=> out_ofs[7:6] == $past(in_instr[6:5])
      && out_ofs[5:3] == $past(in_instr[12:10]))
    else $error("doubleword offset bits misplaced");
  // Double float offset bits
  dfp_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[14:13] == 2'h1 && xlen_sel != `CRX_XLEN128 |=> out_ofs[7:6] == $past(in_instr[6:5])
      && out_ofs[5:3] == $past(in_instr[12:10]))
    else $error("double float offset bits misplaced");
  // Quadword offset bits
  qword_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    in_valid && in_instr[14:13] == 2'h1 && xlen_sel == `CRX_XLEN128 |=> out_ofs[8] == $past(in_instr[10])
      && out_ofs[7:6] == $past(in_instr[6:5]) && out_ofs[5:4] == $past(in_instr[12:11]))
    else $error("quadword offset bits misplaced");
  // Float forms never quadword
  fp_size_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_valid && out_is_fp |-> out_size != 3'h4)
    else $error("float access with quadword size");
endmodule

// ===== tb/crx_lsu_model.sv
`timescale 1ns/10ps
// ****************************
// Load/store unit stand-in
// ****************************
module crx_lsu_model
  import crx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic valid,
  input wire logic [24:0] op,
  output logic stb,
  output logic [24:0] rec
);
  typedef struct packed {
    logic stb;
    logic [24:0] rec;
  } crx_sink_t;
  crx_sink_t st_ff;
  crx_sink_t nxt_st;
  // Take each issued operation
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stb = valid;
    if (valid) begin
      nxt_st.rec = op;
    end
  end
  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign stb = st_ff.stb;
  assign rec = st_ff.rec;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %0t: mismatch %h vs %h", $time, g, e); end end
// ****************************
// Expander bench
// ****************************
module testbench
  import crx_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic in_valid = 1'b0;
  logic [15:0] in_instr = 16'h0000;
  logic [1:0] xlen_sel = 2'h0;
  logic has_f = 1'b0;
  logic has_d = 1'b0;
  logic out_valid, out_is_store, out_is_fp, out_illegal, stb;
  logic [2:0] out_size;
  logic [4:0] out_rd, out_rs1;
  logic [8:0] out_ofs;
  logic [24:0] rec, e;
  logic [24:0] exp_q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 10;
  crx_expander u_dut (.clk(clk), .rst_b(rst_b), .in_valid(in_valid), .in_instr(in_instr), .xlen_sel(xlen_sel),
    .has_f(has_f), .has_d(has_d), .out_valid(out_valid), .out_is_store(out_is_store), .out_is_fp(out_is_fp),
    .out_illegal(out_illegal), .out_size(out_size), .out_rd(out_rd), .out_rs1(out_rs1), .out_ofs(out_ofs));
  crx_lsu_model u_lsu (.clk(clk), .rst_b(rst_b), .valid(out_valid), .stb(stb), .rec(rec),
    .op({out_illegal, out_is_store, out_is_fp, out_size, out_rd, out_rs1, out_ofs}));
  // Reference decode: {illegal, store, fp, size, rd, rs1, ofs}
  function automatic logic [24:0] expect_op(logic [15:0] i, logic [1:0] x, logic f, logic d);
    logic [8:0] ow, od;
    ow = {2'b00, i[5], i[12:10], i[6], 2'b00};
    od = {1'b0, i[6:5], i[12:10], 3'b000};
    if (i[1:0] != 2'b00 || i[14:13] == 2'b00) return {1'b1, 24'h000000};
    if (i[14:13] == 2'b10) return {1'b0, i[15], 1'b0, 3'h2, 2'b01, i[4:2], 2'b01, i[9:7], ow};
    if (i[14:13] == 2'b01 && x == 2'h2) return {1'b0, i[15], 1'b0, 3'h4, 2'b01, i[4:2], 2'b01, i[9:7],
      i[10], i[6:5], i[12:11], 4'h0};
    if (i[14:13] == 2'b01) return {~d, i[15], 1'b1, 3'h3, 2'b01, i[4:2], 2'b01, i[9:7], od};
    if (x == 2'h0) return {~f, i[15], 1'b1, 3'h2, 2'b01, i[4:2], 2'b01, i[9:7], ow};
    return {1'b0, i[15], 1'b0, 3'h3, 2'b01, i[4:2], 2'b01, i[9:7], od};
  endfunction
  // Drive one cycle and note the expected result
  task automatic send(logic [15:0] i, logic [1:0] x, logic f, logic d, logic v);
    @(posedge clk);
    in_valid <= v;
    in_instr <= i;
    xlen_sel <= x;
    has_f <= f;
    has_d <= d;
    if (v) exp_q.push_back(expect_op(i, x, f, d));
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  // Result monitor and timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles > 1000) begin
      n_mismatch++;
      $display("Error %0t: timeout", $time);
      end_sim();
    end else if (stb && exp_q.size() == 0) begin
      n_mismatch++;
      $display("Error %0t: unexpected result", $time);
    end else if (stb) begin
      e = exp_q.pop_front();
      `CHK(rec[24], e[24])
      if (!e[24]) begin
        `CHK(rec[23:19], e[23:19])
        `CHK(rec[18:14], e[18:14])
        `CHK(rec[13:9], e[13:9])
        `CHK(rec[8:0], e[8:0])
      end
    end
  end
  initial begin
    int rv;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    `CHK(out_size, 3'h2)
    // Every funct3 and width, with F and D both off or both on, back to back
    for (int k = 0; k < 128; k++) begin
      send({k[2:0], k[6] ? 13'h1ffc : 13'h0000}, k[4:3], k[5], k[5], 1'b1);
    end
    $display("table test done");
    // Random traffic with gaps and other quadrants
    for (int k = 0; k < 300; k++) begin
      rv = $random(seed);
      send({rv[15:2], rv[17:16] == 2'b00 ? rv[1:0] : 2'b00}, rv[19:18], rv[20], rv[21], rv[22] | rv[23]);
    end
    $display("random test done");
    // Reset in mid-run clears the outputs
    send(16'h0000, 2'h0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    `CHK(out_valid, 1'b0)
    `CHK(out_size, 3'h2)
    rst_b <= 1'b1;
    send(16'h4c5c, 2'h0, 1'b1, 1'b1, 1'b1);
    send(16'hc2a8, 2'h1, 1'b1, 1'b1, 1'b1);
    send(16'h0000, 2'h0, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    `CHK(exp_q.size(), 0)
    $display("reset test done");
    end_sim();
  end
endmodule
